/* inc/nocc_regs.svh */
// offsets, fields, resets and timing counts of the config block
// How it works
// RULE1: int asserts when status and mask bits both set.
// RULE2: masked status bits set but never assert int.
// RULE3: mask 7,6,5: conflict, unreach, ppp close; 3..0: sockets.
// RULE4: software keeps reserved mask bit 4 zero.
// RULE5: retry period = time x 100 us; reset 0x07d0.
// RULE6: retry time high byte 0x0017, low 0x0018.
// RULE7: unanswered socket commands are resent.
// RULE8: past retry count, stop and flag timeout; count resets 0x08.
// RULE9: two-bit size code per socket: 1, 2, 4, 8 KB.
// RULE10: in-order split of one 8 KB pool; misfits unusable.
// RULE11: rx map resets 0x55, 2 KB each.
// RULE12: tx map splits its own pool alike; resets 0x55.
// RULE13: read-only auth type, PAP or CHAP; resets zero.
// RULE14: ppp echo every interval x 25 ms; resets 0x28.
// RULE15: magic register feeds the negotiation option.
// RULE16: unreachable reply latches address and port.
// RULE17: socket modes at 0x0400..0x0700, reset zero.
// RULE18: mode bit 7 multicast, UDP only; group set first.
// RULE19: TCP mode bit 5 acks each packet at once.
// RULE20: multicast bit 5 picks IGMP v1, else v2.
// RULE21: protocol 0 closed, 1 TCP.
// RULE22: int stays low until unmasked status bits clear.
// RULE23: retry timeout is socket event bit 3.
// RULE24: other protocol codes passed raw to engines.
`ifndef NOCC_REGS_SVH
`define NOCC_REGS_SVH
`define NOCC_ADDR_INT_STATUS    15'h0015
`define NOCC_ADDR_INT_MASK      15'h0016
`define NOCC_ADDR_RETRY_HI      15'h0017
`define NOCC_ADDR_RETRY_LO      15'h0018
`define NOCC_ADDR_RETRY_CNT     15'h0019
`define NOCC_ADDR_RX_MAP        15'h001a
`define NOCC_ADDR_TX_MAP        15'h001b
`define NOCC_ADDR_AUTH_HI       15'h001c
`define NOCC_ADDR_AUTH_LO       15'h001d
`define NOCC_ADDR_LCP_INTERVAL  15'h0028
`define NOCC_ADDR_LCP_MAGIC     15'h0029
`define NOCC_ADDR_UNR_IP0       15'h002a
`define NOCC_ADDR_UNR_IP1       15'h002b
`define NOCC_ADDR_UNR_IP2       15'h002c
`define NOCC_ADDR_UNR_IP3       15'h002d
`define NOCC_ADDR_UNR_PORT_HI   15'h002e
`define NOCC_ADDR_UNR_PORT_LO   15'h002f
`define NOCC_MODE_PAGE_HI       5'h01
`define NOCC_MODE_PAGE_LO       8'h00
`define NOCC_RST_INT_MASK       8'h00
`define NOCC_RST_RETRY_TIME     16'h07d0
`define NOCC_RST_RETRY_CNT      8'h08
`define NOCC_RST_BUF_MAP        8'h55
`define NOCC_RST_AUTH           16'h0000
`define NOCC_RST_LCP_INTERVAL   8'h28
`define NOCC_RST_LCP_MAGIC      8'h00
`define NOCC_RST_UNR_IP         32'h0000_0000
`define NOCC_RST_UNR_PORT       16'h0000
`define NOCC_RST_SOCK_MODE      8'h00
`define NOCC_RST_ALLOC_KB       16'h2222
`define NOCC_RST_ALLOC_BASE     16'h6420
`define NOCC_RST_ALLOC_USE      4'hf
`define NOCC_INT_CONFLICT_BIT   7
`define NOCC_INT_PPP_CLOSE_BIT  5
`define NOCC_SOCK_TIMEOUT_BIT   3
`define NOCC_MODE_MULTI_BIT     7
`define NOCC_MODE_NDMC_BIT      5
`define NOCC_PROTO_CLOSED       4'h0
`define NOCC_PROTO_TCP          4'h1
`define NOCC_PROTO_UDP          4'h2
`define NOCC_POOL_KB            5'h08
`define NOCC_CLK_PERIOD_NS      20
`define NOCC_RETRY_UNIT_US      100
`define NOCC_RETRY_UNIT_CYC     ((`NOCC_RETRY_UNIT_US * 1000) / `NOCC_CLK_PERIOD_NS)
`define NOCC_LCP_UNIT_MS        25
`define NOCC_LCP_UNIT_CYC       ((`NOCC_LCP_UNIT_MS * 1000000) / `NOCC_CLK_PERIOD_NS)
`endif

/* inc/nocc_pkg.sv */
// shared types and size decode
`default_nettype none
package nocc_pkg;
   // gray path idle -> wait -> done
   typedef enum logic [1:0] {
      nocc_rt_idle = 2'b00,
      nocc_rt_wait = 2'b01,
      nocc_rt_done = 2'b11
   } nocc_retry_state_t;
   typedef logic [3:0] nocc_kb_t;
   // two-bit size code to kilobytes: 1, 2, 4, 8
   function automatic nocc_kb_t nocc_code_kb(input logic [1:0] code);
      nocc_code_kb = 4'h1 << code;
   endfunction
endpackage
`default_nettype wire

/* rtl/nocc_retry.sv */
// per-socket retransmission timer and retry counter
`timescale 1ns/1ps
`default_nettype none
module nocc_retry (
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic        tick,
   input  wire logic        arm,
   input  wire logic        reply,
   input  wire logic [15:0] retry_time,
   input  wire logic [7:0]  retry_limit,
   output logic             resend,
   output logic             timeout
);
   nocc_pkg::nocc_retry_state_t state_q;
   logic [15:0]                 elapsed_q;
   logic [7:0]                  tries_q;
   logic                        expire;
   // expiry on the tick reaching the count
   assign expire = tick && ((elapsed_q + 16'h0001) >= retry_time);
   // RULE7 RULE8 resend until count spent
   always_ff @(posedge sys_clk) begin
      resend  <= 1'b0;
      timeout <= 1'b0;
      if (!reset_n) begin
         state_q   <= nocc_pkg::nocc_rt_idle;
         elapsed_q <= 16'h0000;
         tries_q   <= 8'h00;
      end else begin
         case (state_q)
            nocc_pkg::nocc_rt_idle: begin
               elapsed_q <= 16'h0000;
               tries_q   <= 8'h00;
               if (arm) begin
                  state_q <= nocc_pkg::nocc_rt_wait;
               end
            end
            nocc_pkg::nocc_rt_wait: begin
               if (reply) begin
                  state_q <= nocc_pkg::nocc_rt_idle;
               end else if (expire) begin
                  elapsed_q <= 16'h0000;
                  // timeout on the next expiry once retries reach the limit
                  if (tries_q >= retry_limit) begin
                     timeout <= 1'b1;
                     state_q <= nocc_pkg::nocc_rt_done;
                  end else begin
                     tries_q <= tries_q + 8'h01;
                     resend  <= 1'b1;
                  end
               end else if (tick) begin
                  elapsed_q <= elapsed_q + 16'h0001;
               end
            end
            default: begin
               state_q <= nocc_pkg::nocc_rt_idle;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* rtl/nocc_buf_alloc.sv */
// splits one 8 KB pool over sockets 0 to 3 in order
`timescale 1ns/1ps
`default_nettype none
`include "nocc_regs.svh"
module nocc_buf_alloc (
   input  wire logic       sys_clk,
   input  wire logic       reset_n,
   input  wire logic [7:0] size_map,
   output logic     [15:0] sock_kb,
   output logic     [15:0] sock_base_kb,
   output logic     [3:0]  sock_usable
);
   logic [15:0] kb_d;
   logic [15:0] base_d;
   logic [3:0]  use_d;
   // first fit in socket order; a later small socket may still fit
   always_comb begin : walk
      logic [4:0] used;
      logic [4:0] need;
      used   = 5'h00;
      need   = 5'h00;
      kb_d   = 16'h0000;
      base_d = 16'h0000;
      use_d  = 4'h0;
      for (int s = 0; s < 4; s++) begin
         // RULE9 field per socket
         need = {1'b0, nocc_pkg::nocc_code_kb(size_map[2*s +: 2])};
         // RULE10 in-order allocation
         if ((used + need) <= `NOCC_POOL_KB) begin
            kb_d[4*s +: 4]   = need[3:0];
            base_d[4*s +: 4] = used[3:0];
            use_d[s]         = 1'b1;
            used             = used + need;
         end
      end
   end
   // registered for a stable split
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         sock_kb      <= `NOCC_RST_ALLOC_KB;
         sock_base_kb <= `NOCC_RST_ALLOC_BASE;
         sock_usable  <= `NOCC_RST_ALLOC_USE;
      end else begin
         sock_kb      <= kb_d;
         sock_base_kb <= base_d;
         sock_usable  <= use_d;
      end
   end
endmodule
`default_nettype wire

/* rtl/nocc_top.sv */
// common config and status registers
`timescale 1ns/1ps
`default_nettype none
`include "nocc_regs.svh"

module nocc_top #(
   parameter int RETRY_UNIT_CYC = `NOCC_RETRY_UNIT_CYC,
   parameter int LCP_UNIT_CYC   = `NOCC_LCP_UNIT_CYC
) (
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   // host bus
   input  wire logic [14:0] host_addr,
   input  wire logic        host_cs_n,
   input  wire logic        host_rd_n,
   input  wire logic        host_wr_n,
   input  wire logic [7:0]  host_data_i,
   output logic      [7:0]  host_data_o,
   output logic             host_data_oe_n,
   output logic             int_n,
   // from the engines
   input  wire logic        conflict_evt,
   input  wire logic        unreach_evt,
   input  wire logic [31:0] unreach_ip,
   input  wire logic [15:0] unreach_port,
   input  wire logic        ppp_close_evt,
   input  wire logic [3:0]  sock_event_pending,
   input  wire logic        auth_load,
   input  wire logic [15:0] auth_value,
   input  wire logic        ppp_mode,
   input  wire logic [3:0]  retry_arm,
   input  wire logic [3:0]  retry_reply,
   // toward the engines
   output logic      [3:0]  retry_resend,
   output logic      [31:0] sock_event_set,
   output logic             lcp_echo_req,
   output logic      [7:0]  lcp_magic,
   output logic      [15:0] rx_kb,
   output logic      [15:0] rx_base_kb,
   output logic      [3:0]  rx_usable,
   output logic      [15:0] tx_kb,
   output logic      [15:0] tx_base_kb,
   output logic      [3:0]  tx_usable,
   output logic      [31:0] sock_mode_flat,
   output logic      [3:0]  sock_closed,
   output logic      [3:0]  sock_tcp,
   output logic      [3:0]  sock_no_delay_ack,
   output logic      [3:0]  sock_multicast,
   output logic      [3:0]  sock_igmp_v1
);

   logic [7:0]  int_mask_q;
   logic [2:0]  evt_flag_q;     // conflict, unreachable, ppp close
   logic [2:0]  evt_set;
   logic [2:0]  evt_clr;
   logic [7:0]  global_status;
   logic [15:0] retry_time_q;
   logic [7:0]  retry_limit_q;
   logic [7:0]  rx_map_q;
   logic [7:0]  tx_map_q;
   logic [15:0] auth_type_q;
   logic [7:0]  lcp_interval_q;
   logic [7:0]  lcp_magic_q;
   logic [31:0] unr_ip_q;
   logic [15:0] unr_port_q;
   logic [7:0]  sock_mode_q [4];
   logic        wr_prev_q;
   logic        wr_stb;
   logic        rd_act;
   logic [7:0]  rd_d;
   logic [3:0]  timeout_w;
   logic [12:0] tick_cnt_q;
   logic        tick_q;
   logic [20:0] lcp_cnt_q;
   logic        lcp_unit_q;
   logic [7:0]  lcp_units_q;

   // mode register at the head of each socket page
   function automatic logic is_mode_addr(input logic [14:0] a);
      is_mode_addr = (a[14:10] == `NOCC_MODE_PAGE_HI) && (a[7:0] == `NOCC_MODE_PAGE_LO);
   endfunction

   // write hit on one byte address
   function automatic logic wr_hit(input logic [14:0] a);
      wr_hit = wr_stb && (host_addr == a);
   endfunction

   // write on the strobe's first edge,
   // so a held strobe writes only once
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         wr_prev_q <= 1'b0;
      end else begin
         wr_prev_q <= !host_cs_n && !host_wr_n;
      end
   end

   assign wr_stb         = !host_cs_n && !host_wr_n && !wr_prev_q;
   assign rd_act         = !host_cs_n && !host_rd_n;
   assign host_data_oe_n = !rd_act;

   // read mux; unmapped space reads zero
   always_comb begin
      rd_d = 8'h00;
      if (host_addr == `NOCC_ADDR_INT_STATUS) begin
         rd_d = global_status;
      end else if (host_addr == `NOCC_ADDR_INT_MASK) begin
         rd_d = int_mask_q;
      end else if (host_addr == `NOCC_ADDR_RETRY_HI) begin
         rd_d = retry_time_q[15:8];
      end else if (host_addr == `NOCC_ADDR_RETRY_LO) begin
         rd_d = retry_time_q[7:0];
      end else if (host_addr == `NOCC_ADDR_RETRY_CNT) begin
         rd_d = retry_limit_q;
      end else if (host_addr == `NOCC_ADDR_RX_MAP) begin
         rd_d = rx_map_q;
      end else if (host_addr == `NOCC_ADDR_TX_MAP) begin
         rd_d = tx_map_q;
      end else if (host_addr == `NOCC_ADDR_AUTH_HI) begin
         rd_d = auth_type_q[15:8];
      end else if (host_addr == `NOCC_ADDR_AUTH_LO) begin
         rd_d = auth_type_q[7:0];
      end else if (host_addr == `NOCC_ADDR_LCP_INTERVAL) begin
         rd_d = lcp_interval_q;
      end else if (host_addr == `NOCC_ADDR_LCP_MAGIC) begin
         rd_d = lcp_magic_q;
      end else if (host_addr == `NOCC_ADDR_UNR_IP0) begin
         rd_d = unr_ip_q[31:24];
      end else if (host_addr == `NOCC_ADDR_UNR_IP1) begin
         rd_d = unr_ip_q[23:16];
      end else if (host_addr == `NOCC_ADDR_UNR_IP2) begin
         rd_d = unr_ip_q[15:8];
      end else if (host_addr == `NOCC_ADDR_UNR_IP3) begin
         rd_d = unr_ip_q[7:0];
      end else if (host_addr == `NOCC_ADDR_UNR_PORT_HI) begin
         rd_d = unr_port_q[15:8];
      end else if (host_addr == `NOCC_ADDR_UNR_PORT_LO) begin
         rd_d = unr_port_q[7:0];
      end else if (is_mode_addr(host_addr)) begin
         rd_d = sock_mode_q[host_addr[9:8]];
      end
   end

   // read data one cycle behind the address
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         host_data_o <= 8'h00;
      end else begin
         host_data_o <= rd_d;
      end
   end

   // sticky events on top, socket summaries below;
   // socket bits follow their registers, no clear here
   assign global_status = {evt_flag_q, 1'b0, sock_event_pending};
   assign evt_set       = {conflict_evt, unreach_evt, ppp_close_evt};
   assign evt_clr       = wr_hit(`NOCC_ADDR_INT_STATUS) ?
                          host_data_i[`NOCC_INT_CONFLICT_BIT:`NOCC_INT_PPP_CLOSE_BIT] : 3'h0;

   // write-one-to-clear; a new event in the same cycle wins
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         evt_flag_q <= 3'h0;
      end else begin
         evt_flag_q <= (evt_flag_q & ~evt_clr) | evt_set;
      end
   end

   // interrupt mask
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         int_mask_q <= `NOCC_RST_INT_MASK;
      end else if (wr_hit(`NOCC_ADDR_INT_MASK)) begin
         // RULE4 reserved bit harmless
         int_mask_q <= host_data_i;
      end
   end

   // RULE1 RULE2 RULE3 masked interrupt
   // RULE22 low while pending
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         int_n <= 1'b1;
      end else begin
         int_n <= !(|(global_status & int_mask_q));
      end
   end

   // retransmission settings
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         // RULE5 retry time reset
         retry_time_q  <= `NOCC_RST_RETRY_TIME;
         // RULE8 retry count reset
         retry_limit_q <= `NOCC_RST_RETRY_CNT;
      end else begin
         // RULE6 high byte first
         if (wr_hit(`NOCC_ADDR_RETRY_HI)) begin
            retry_time_q[15:8] <= host_data_i;
         end
         if (wr_hit(`NOCC_ADDR_RETRY_LO)) begin
            retry_time_q[7:0] <= host_data_i;
         end
         if (wr_hit(`NOCC_ADDR_RETRY_CNT)) begin
            retry_limit_q <= host_data_i;
         end
      end
   end

   // size maps; a change re-splits the pool at once,
   // so rewrite only with all sockets closed
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         // RULE11 RULE12 default split
         rx_map_q <= `NOCC_RST_BUF_MAP;
         tx_map_q <= `NOCC_RST_BUF_MAP;
      end else begin
         if (wr_hit(`NOCC_ADDR_RX_MAP)) begin
            rx_map_q <= host_data_i;
         end
         if (wr_hit(`NOCC_ADDR_TX_MAP)) begin
            tx_map_q <= host_data_i;
         end
      end
   end

   // ppp settings and agreed authentication
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         lcp_interval_q <= `NOCC_RST_LCP_INTERVAL;
         lcp_magic_q    <= `NOCC_RST_LCP_MAGIC;
         auth_type_q    <= `NOCC_RST_AUTH;
      end else begin
         if (wr_hit(`NOCC_ADDR_LCP_INTERVAL)) begin
            lcp_interval_q <= host_data_i;
         end
         if (wr_hit(`NOCC_ADDR_LCP_MAGIC)) begin
            lcp_magic_q <= host_data_i;
         end
         // RULE13 read-only auth type
         if (auth_load) begin
            auth_type_q <= auth_value;
         end
      end
   end

   // RULE15 magic number to negotiation
   assign lcp_magic = lcp_magic_q;

   // RULE16 capture unreachable target
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         unr_ip_q   <= `NOCC_RST_UNR_IP;
         unr_port_q <= `NOCC_RST_UNR_PORT;
      end else if (unreach_evt) begin
         unr_ip_q   <= unreach_ip;
         unr_port_q <= unreach_port;
      end
   end

   // RULE17 socket mode registers
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         for (int s = 0; s < 4; s++) begin
            sock_mode_q[s] <= `NOCC_RST_SOCK_MODE;
         end
      end else if (wr_stb && is_mode_addr(host_addr)) begin
         sock_mode_q[host_addr[9:8]] <= host_data_i;
      end
   end

   // registered socket option decodes
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         sock_mode_flat    <= 32'h0000_0000;
         sock_closed       <= 4'hf;
         sock_tcp          <= 4'h0;
         sock_no_delay_ack <= 4'h0;
         sock_multicast    <= 4'h0;
         sock_igmp_v1      <= 4'h0;
      end else begin
         for (int s = 0; s < 4; s++) begin
            // RULE24 raw mode for other codes
            sock_mode_flat[8*s +: 8] <= sock_mode_q[s];
            // RULE21 closed and tcp codes
            sock_closed[s] <= sock_mode_q[s][3:0] == `NOCC_PROTO_CLOSED;
            sock_tcp[s]    <= sock_mode_q[s][3:0] == `NOCC_PROTO_TCP;
            // RULE19 immediate ack in tcp
            sock_no_delay_ack[s] <= (sock_mode_q[s][3:0] == `NOCC_PROTO_TCP) &&
                                    sock_mode_q[s][`NOCC_MODE_NDMC_BIT];
            // RULE18 multicast only for udp
            sock_multicast[s] <= (sock_mode_q[s][3:0] == `NOCC_PROTO_UDP) &&
                                 sock_mode_q[s][`NOCC_MODE_MULTI_BIT];
            // RULE20 igmp version select
            sock_igmp_v1[s] <= (sock_mode_q[s][3:0] == `NOCC_PROTO_UDP) &&
                               sock_mode_q[s][`NOCC_MODE_MULTI_BIT] &&
                               sock_mode_q[s][`NOCC_MODE_NDMC_BIT];
         end
      end
   end

   // RULE5 100 us retry tick
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         tick_cnt_q <= 13'h0000;
         tick_q     <= 1'b0;
      end else if (tick_cnt_q >= 13'(RETRY_UNIT_CYC - 1)) begin
         tick_cnt_q <= 13'h0000;
         tick_q     <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 13'h0001;
         tick_q     <= 1'b0;
      end
   end

   // RULE14 echo timer in ppp mode
   // restarts when ppp mode drops, so a new
   // session waits a full interval
   always_ff @(posedge sys_clk) begin
      if (!reset_n || !ppp_mode) begin
         lcp_cnt_q  <= 21'h000000;
         lcp_unit_q <= 1'b0;
      end else if (lcp_cnt_q >= 21'(LCP_UNIT_CYC - 1)) begin
         lcp_cnt_q  <= 21'h000000;
         lcp_unit_q <= 1'b1;
      end else begin
         lcp_cnt_q  <= lcp_cnt_q + 21'h000001;
         lcp_unit_q <= 1'b0;
      end
   end

   // interval of zero never sends an echo
   always_ff @(posedge sys_clk) begin
      lcp_echo_req <= 1'b0;
      if (!reset_n || !ppp_mode) begin
         lcp_units_q <= 8'h00;
      end else if (lcp_unit_q && (lcp_interval_q != 8'h00)) begin
         if ((lcp_units_q + 8'h01) >= lcp_interval_q) begin
            lcp_units_q  <= 8'h00;
            lcp_echo_req <= 1'b1;
         end else begin
            lcp_units_q <= lcp_units_q + 8'h01;
         end
      end
   end

   // one retry engine per socket
   for (genvar gi = 0; gi < 4; gi++) begin : g_retry
      nocc_retry u_retry (
         .sys_clk     (sys_clk),
         .reset_n     (reset_n),
         .tick        (tick_q),
         .arm         (retry_arm[gi]),
         .reply       (retry_reply[gi]),
         .retry_time  (retry_time_q),
         .retry_limit (retry_limit_q),
         .resend      (retry_resend[gi]),
         .timeout     (timeout_w[gi])
      );

      // RULE23 timeout at bit 3
      assign sock_event_set[8*gi +: 8] = timeout_w[gi] ?
                                        (8'h01 << `NOCC_SOCK_TIMEOUT_BIT) : 8'h00;
   end

   // RULE9 RULE10 RULE11 receive pool split
   nocc_buf_alloc u_rx_alloc (
      .sys_clk      (sys_clk),
      .reset_n      (reset_n),
      .size_map     (rx_map_q),
      .sock_kb      (rx_kb),
      .sock_base_kb (rx_base_kb),
      .sock_usable  (rx_usable)
   );

   // RULE12 transmit pool split
   nocc_buf_alloc u_tx_alloc (
      .sys_clk      (sys_clk),
      .reset_n      (reset_n),
      .size_map     (tx_map_q),
      .sock_kb      (tx_kb),
      .sock_base_kb (tx_base_kb),
      .sock_usable  (tx_usable)
   );

endmodule
`default_nettype wire

/* verification/nocc_host.sv */
// host model on the register bus
`timescale 1ns/1ps
`default_nettype none
`include "nocc_regs.svh"
module nocc_host (
   input  wire logic        sys_clk,
   output logic      [14:0] host_addr,
   output logic             host_cs_n,
   output logic             host_rd_n,
   output logic             host_wr_n,
   output logic      [7:0]  host_data_i,
   input  wire logic [7:0]  host_data_o
);
   // bus idle, nothing selected
   initial {host_cs_n, host_rd_n, host_wr_n, host_addr, host_data_i} = 26'h3800000;
   // one write, strobe held to the taking edge
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a == `NOCC_ADDR_INT_MASK) v[4] = 1'b0;
      @(posedge sys_clk);
      host_addr <= a;
      host_data_i <= v;
      {host_cs_n, host_wr_n} <= 2'h0;
      @(posedge sys_clk);
      {host_cs_n, host_wr_n} <= 2'h3;
      host_data_i <= ~v; // no stale byte after release
   endtask
   // one read; data a cycle after the address
   task automatic rd(input logic [14:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      host_addr <= a;
      {host_cs_n, host_rd_n} <= 2'h0;
      repeat (2) @(posedge sys_clk);
      d = host_data_o;
      {host_cs_n, host_rd_n} <= 2'h3;
   endtask
endmodule
`default_nettype wire

/* verification/nocc_top_assertions.sv */
// port checks
`timescale 1ns/1ps
`default_nettype none
module nocc_top_assertions (
   input wire logic        sys_clk,
   input wire logic        reset_n,
   input wire logic        host_wr_n,
   input wire logic        ppp_mode,
   input wire logic        lcp_echo_req,
   input wire logic [7:0]  lcp_magic,
   input wire logic [15:0] rx_kb,
   input wire logic [15:0] tx_kb,
   input wire logic [3:0]  rx_usable,
   input wire logic [3:0]  tx_usable,
   input wire logic [3:0]  retry_resend,
   input wire logic [31:0] sock_event_set,
   input wire logic [3:0]  sock_no_delay_ack,
   input wire logic [3:0]  sock_multicast,
   input wire logic [3:0]  sock_igmp_v1
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // three edges with no write strobe
   sequence wr_quiet;
      host_wr_n ##1 host_wr_n ##1 host_wr_n;
   endsequence
   // echo is a lone pulse
   sequence echo_end;
      $past(ppp_mode) ##1 !lcp_echo_req;
   endsequence
   magic_hold_a: assert property (wr_quiet |-> $stable(lcp_magic))
      else $error("magic moved with no write");
   echo_ppp_a: assert property (lcp_echo_req |-> echo_end)
      else $error("echo outside link or too long");
   resend_pulse_a: assert property (|retry_resend |=> !(|(retry_resend & $past(retry_resend))))
      else $error("resend longer than one cycle");
   evt_bit3_a: assert property ((sock_event_set & 32'hf7f7f7f7) == 32'h0)
      else $error("event set outside timeout bit");
   pool_sum_a: assert property (({2'h0, rx_kb[3:0]} + rx_kb[7:4] + rx_kb[11:8] + rx_kb[15:12]) <= 6'h08
      && ({2'h0, tx_kb[3:0]} + tx_kb[7:4] + tx_kb[11:8] + tx_kb[15:12]) <= 6'h08)
      else $error("pool overcommitted");
   usable_first_a: assert property (rx_usable[0] && tx_usable[0]
      && ((rx_kb[15:12] == 4'h0) == !rx_usable[3]))
      else $error("usable flags disagree with sizes");
   igmp_gate_a: assert property ((sock_igmp_v1 & ~sock_multicast) == 4'h0)
      else $error("igmp version without multicast");
   nd_excl_a: assert property ((sock_no_delay_ack & sock_multicast) == 4'h0)
      else $error("no delay ack on a multicast socket");
endmodule
bind nocc_top nocc_top_assertions u_chk (.*);
`default_nettype wire

/* verification/nocc_top_bench.sv */
// self-checking bench
`timescale 1ns/1ps
`default_nettype none
module nocc_top_bench;
   logic sys_clk = 1'b0, reset_n = 1'b0, conflict_evt = 1'b0, unreach_evt = 1'b0;
   logic ppp_close_evt = 1'b0, auth_load = 1'b0, ppp_mode = 1'b0;
   logic host_cs_n, host_rd_n, host_wr_n, int_n, lcp_echo_req;
   logic [14:0] host_addr;
   logic [7:0] host_data_i, host_data_o, lcp_magic;
   logic [3:0] sock_event_pending = 4'h0, retry_arm = 4'h0, retry_reply = 4'h0;
   logic [3:0] retry_resend, rx_usable, tx_usable, sock_tcp, sock_no_delay_ack;
   logic [3:0] sock_multicast, sock_igmp_v1, sock_closed;
   logic [15:0] auth_value = 16'h0, unreach_port = 16'h0, rx_kb, tx_kb, rx_base_kb, tx_base_kb;
   logic [31:0] unreach_ip = 32'h0, sock_event_set, sock_mode_flat;
   int n_fail = 0, cmp_count = 0, cyc = 0, k, r;
   // short unit counts keep the run brief
   nocc_top #(.RETRY_UNIT_CYC(10), .LCP_UNIT_CYC(20)) u_dut (.*, .host_data_oe_n());
   nocc_host u_host (.*);
   // 50 MHz clock and hang guard
   always #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         test_done;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [14:0] a, input logic [7:0] e);
      logic [7:0] d;
      u_host.rd(a, d);
      chk(d, e);
   endtask
   task automatic t_reset;
      logic [14:0] a [15] = '{15'h16, 15'h17, 15'h18, 15'h19, 15'h1a, 15'h1b, 15'h1c, 15'h1d,
         15'h28, 15'h29, 15'h2a, 15'h2f, 15'h400, 15'h700, 15'h30};
      logic [7:0] e [15] = '{8'h0, 8'h07, 8'hd0, 8'h08, 8'h55, 8'h55, 8'h0, 8'h0, 8'h28, 8'h0,
         8'h0, 8'h0, 8'h0, 8'h0, 8'h0};
      for (int i = 0; i < 15; i++) rdc(a[i], e[i]);
   endtask
   task automatic t_irq;
      u_host.wr(15'h16, 8'h81);
      conflict_evt <= 1'b1;
      @(posedge sys_clk) conflict_evt <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk(int_n, 1'b0);
      u_host.wr(15'h15, 8'h80);
      ppp_close_evt <= 1'b1;
      @(posedge sys_clk) ppp_close_evt <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk(int_n, 1'b1);
      rdc(15'h15, 8'h20);
      sock_event_pending <= 4'h1;
      repeat (2) @(posedge sys_clk);
      chk(int_n, 1'b0);
      sock_event_pending <= 4'h0;
      repeat (2) @(posedge sys_clk);
      chk(int_n, 1'b1);
   endtask
   task automatic t_retry;
      u_host.wr(15'h17, 8'h00);
      u_host.wr(15'h18, 8'h03);
      u_host.wr(15'h19, 8'h02);
      retry_arm <= 4'h1;
      @(posedge sys_clk) retry_arm <= 4'h0;
      r = 0;
      for (k = 0; k < 300 && sock_event_set[3] !== 1'b1; k++) begin
         @(posedge sys_clk);
         if (retry_resend[0] === 1'b1) r++;
      end
      chk(r, 2);
      chk(sock_event_set[3], 1'b1);
   endtask
   task automatic t_map_mode;
      u_host.wr(15'h1a, 8'haa);
      u_host.wr(15'h1b, 8'he4);
      u_host.wr(15'h400, 8'h21);
      u_host.wr(15'h500, 8'ha2);
      repeat (3) @(posedge sys_clk);
      chk({rx_kb, rx_usable}, 20'h00443);
      chk({tx_kb, tx_usable}, 20'h04217);
      chk({rx_base_kb, tx_base_kb}, 32'h0040_0310);
      chk(sock_mode_flat[15:0], 16'ha221);
      chk({sock_closed, sock_tcp[0], sock_no_delay_ack[0], sock_multicast[1], sock_igmp_v1[1]},
         8'hcf);
   endtask
   task automatic t_cap_lcp;
      {unreach_ip, unreach_port, auth_value} <= 64'hc0a8000b_1388_c223;
      {unreach_evt, auth_load} <= 2'h3;
      @(posedge sys_clk) {unreach_evt, auth_load} <= 2'h0;
      rdc(15'h2a, 8'hc0);
      rdc(15'h2d, 8'h0b);
      rdc(15'h2f, 8'h88);
      u_host.wr(15'h1c, 8'h00);
      rdc(15'h1c, 8'hc2);
      u_host.wr(15'h28, 8'h02);
      u_host.wr(15'h29, 8'h5a);
      repeat (3) @(posedge sys_clk);
      chk(lcp_magic, 8'h5a);
      ppp_mode <= 1'b1;
      for (k = 0; k < 100 && lcp_echo_req !== 1'b1; k++) @(posedge sys_clk);
      chk(k >= 38 && k <= 44, 1'b1);
      ppp_mode <= 1'b0;
   endtask
   task automatic test_done;
      $display("fails=%0d compares=%0d", n_fail, cmp_count);
      if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // reset, then each scenario
   initial begin
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_reset;
      t_irq;
      t_retry;
      t_map_mode;
      t_cap_lcp;
      test_done;
   end
endmodule
`default_nettype wire
